//--- rtl/atr_params.svh
// timing counts, widths and code constants for the converter trigger controller
`ifndef ATR_PARAMS_SVH
`define ATR_PARAMS_SVH
`define ATR_CLK_MHZ 20
`define ATR_DATA_W 14
`define ATR_TRIG_HIGH_NS 20
`define ATR_TRIG_HIGH_MIN_NS 10
`define ATR_TRIG_HIGH_GAP_LO_NS 110
`define ATR_TRIG_HIGH_GAP_HI_NS 160
`define ATR_TRIG_HIGH_MAX_NS 300
`define ATR_TRIG_LOW_MIN_NS 30
`define ATR_PERIOD_NS 333
`define ATR_TRIG_HIGH_CYC ((`ATR_TRIG_HIGH_NS * `ATR_CLK_MHZ + 999) / 1000)
`define ATR_TRIG_LOW_MIN_CYC ((`ATR_TRIG_LOW_MIN_NS * `ATR_CLK_MHZ + 999) / 1000)
`define ATR_PERIOD_CYC ((`ATR_PERIOD_NS * `ATR_CLK_MHZ + 999) / 1000)
`define ATR_CODE_ZERO 14'h2000
`define ATR_CODE_NEG_FS 14'h0000
`define ATR_CODE_POS_FS 14'h3FFF
`endif

//--- rtl/atr_pkg.sv
// types shared by the converter trigger controller
package atr_pkg;
    typedef enum logic [3:0]
    {
        ATR_IDLE = 4'h1,
        ATR_HIGH = 4'h2,
        ATR_LOW = 4'h4,
        ATR_WAIT = 4'h8
    } atr_state_t;
endpackage

//--- rtl/atr_buf2.sv
// two-entry skid buffer carrying captured results to the user side
`timescale 1ns/1ps
module atr_buf2
#(
    parameter int W = 15
)
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    logic [W-1:0] mem_q [0:1];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // a zero-width word has nothing to carry
    if (W < 1)
    begin
        $error("buffer width must be at least one bit");
    end

    // honest full and empty from the fill count
    assign in_ready_out = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_q[rp_q];

    // storage array, written only on push
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end
        else if (ce_in && push)
        begin
            mem_q[wp_q] <= in_data_in;
        end
    end

    // pointers and count
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else if (ce_in)
        begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

//--- rtl/atr_ctrl.sv
// host controller that paces the converter trigger and captures results
// Summary of operation
// - trigger high 10-110 or 160-300 ns
// - slower rates: longer high, low at least 30ns
// - reference train 3MHz with 20 ns high; here the high lasts one 50 ns clock and rises come at least 9 clocks apart
// - continuous mode gives uninterrupted trigger train; here the train pauses while the result buffer is full
// - warmup keeps triggers running, supplies first
`timescale 1ns/1ps
`include "atr_params.svh"
module atr_ctrl
    import atr_pkg::*;
#(
    parameter int DATA_W = `ATR_DATA_W,
    parameter int HIGH_CYC = `ATR_TRIG_HIGH_CYC,
    parameter int PERIOD_CYC = `ATR_PERIOD_CYC
)
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic supplies_ok_in,
    input wire logic run_in,
    input wire logic single_in,
    input wire logic busy_in,
    input wire logic [DATA_W-1:0] adc_data_in,
    output logic trig_out,
    output logic res_valid_out,
    input wire logic res_ready_in,
    output logic [DATA_W-1:0] res_data_out,
    output logic res_invalid_out,
    output logic overrun_out,
    output logic converting_out
);
    // ****************************************
    // elaboration checks
    // ****************************************
    localparam int LOW_CYC = `ATR_TRIG_LOW_MIN_CYC;
    localparam int HIGH_MAX_CYC = (`ATR_TRIG_HIGH_MAX_NS * `ATR_CLK_MHZ) / 1000;
    localparam int GAP_LO_CYC = (`ATR_TRIG_HIGH_GAP_LO_NS * `ATR_CLK_MHZ) / 1000;
    localparam int GAP_HI_CYC = (`ATR_TRIG_HIGH_GAP_HI_NS * `ATR_CLK_MHZ + 999) / 1000;

    // refused while elaborating, so a bad setting never reaches a netlist
    if (DATA_W != `ATR_DATA_W)
    begin
        $error("data width must match the converter");
    end
    if (HIGH_CYC < 1 || PERIOD_CYC < HIGH_CYC + LOW_CYC + 2 || PERIOD_CYC > 255)
    begin
        $error("trigger timing parameters out of range");
    end
    if (PERIOD_CYC < 8 && HIGH_CYC > GAP_LO_CYC && HIGH_CYC < GAP_HI_CYC)
    begin
        $error("trigger high time falls in the forbidden gap");
    end
    if (PERIOD_CYC < 8 && HIGH_CYC > HIGH_MAX_CYC)
    begin
        $error("trigger high time too long at full rate");
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic busy_s1_q;
    logic busy_s2_q;
    logic busy_d1_q;
    logic [DATA_W-1:0] data_s1_q;
    logic [DATA_W-1:0] data_s2_q;

    // two flops ahead of any logic; data is stable once busy has fallen
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
            busy_d1_q <= 1'b0;
            data_s1_q <= '0;
            data_s2_q <= '0;
        end
        else if (ce_in)
        begin
            busy_s1_q <= busy_in;
            busy_s2_q <= busy_s1_q;
            busy_d1_q <= busy_s2_q;
            data_s1_q <= adc_data_in;
            data_s2_q <= data_s1_q;
        end
    end

    logic busy_fall;
    assign busy_fall = busy_d1_q && !busy_s2_q;

    // ****************************************
    // trigger sequencer
    // ****************************************
    atr_state_t state_q;
    logic [7:0] cnt_q;
    logic pending_q;
    logic seen_busy_q;
    logic buf_ready;
    logic want;

    // a new pulse only when the result path can take the answer
    assign want = supplies_ok_in && (run_in || pending_q) && buf_ready;

    // single-shot request held until its pulse goes out
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            pending_q <= 1'b0;
        else if (ce_in)
        begin
            if (single_in)
                pending_q <= 1'b1;
            else if (state_q == ATR_IDLE && want && !busy_s2_q)
                pending_q <= 1'b0;
        end
    end

    // pulse high for HIGH_CYC, low for the rest of the period, then wait for busy low
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_q <= ATR_IDLE;
            cnt_q <= 8'h00;
            seen_busy_q <= 1'b0;
        end
        else if (ce_in)
        begin
            case (state_q)
                ATR_IDLE:
                begin
                    // rising edge is the only start the converter sees
                    if (want && !busy_s2_q)
                    begin
                        state_q <= ATR_HIGH;
                        cnt_q <= 8'(HIGH_CYC - 1);
                    end
                end
                ATR_HIGH:
                begin
                    if (cnt_q == 8'h00)
                    begin
                        state_q <= ATR_LOW;
                        cnt_q <= 8'(PERIOD_CYC - HIGH_CYC - 1);
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                ATR_LOW:
                begin
                    // low phase is at least the minimum low time
                    if (busy_s2_q)
                        seen_busy_q <= 1'b1;
                    if (cnt_q == 8'h00)
                        state_q <= ATR_WAIT;
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                ATR_WAIT:
                begin
                    // never retrigger while busy: that would spoil two results
                    if (!busy_s2_q)
                    begin
                        state_q <= ATR_IDLE;
                        seen_busy_q <= 1'b0;
                    end
                end
                default:
                begin
                    state_q <= ATR_IDLE;
                    cnt_q <= 8'h00;
                    seen_busy_q <= 1'b0;
                end
            endcase
        end
    end

    // trigger pin driven from a flop for a clean pulse width
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            trig_out <= 1'b0;
        else if (ce_in)
            trig_out <= (state_q == ATR_IDLE && want && !busy_s2_q) ||
                        (state_q == ATR_HIGH && cnt_q != 8'h00);
    end

    // ****************************************
    // result capture and validity
    // ****************************************
    logic cap_valid;
    logic [DATA_W:0] cap_word;
    logic busy_at_trig_q;

    // busy seen already high at a trigger means an abort happened
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            busy_at_trig_q <= 1'b0;
        else if (ce_in)
        begin
            if (state_q == ATR_IDLE && want && busy_s2_q)
                busy_at_trig_q <= 1'b1;
            else if (busy_fall)
                busy_at_trig_q <= 1'b0;
        end
    end

    // capture on busy falling; codes pass through unchanged in offset binary
    assign cap_valid = busy_fall;
    assign cap_word = {busy_at_trig_q, data_s2_q};

    // status flags: overrun when a result arrives to a full buffer
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            overrun_out <= 1'b0;
            converting_out <= 1'b0;
        end
        else if (ce_in)
        begin
            if (cap_valid && !buf_ready)
                overrun_out <= 1'b1;
            converting_out <= busy_s2_q || seen_busy_q;
        end
    end

    logic [DATA_W:0] out_word;

    atr_buf2 #(.W(DATA_W + 1)) u_buf
    (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .in_valid_in(cap_valid),
        .in_ready_out(buf_ready),
        .in_data_in(cap_word),
        .out_valid_out(res_valid_out),
        .out_ready_in(res_ready_in),
        .out_data_out(out_word)
    );

    assign res_data_out = out_word[DATA_W-1:0];
    assign res_invalid_out = out_word[DATA_W];
endmodule

//--- verif/atr_ctrl_chk.sv
// port checker for the converter trigger controller
`timescale 1ns/1ps
module atr_ctrl_chk
    import atr_pkg::*;
#(
    parameter int PERIOD_CYC = 17
)
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic supplies_ok_in,
    input wire logic run_in,
    input wire logic busy_in,
    input wire logic res_ready_in,
    input wire logic trig_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    logic [7:0] gap_q;
    // cycles since the last trigger, saturating so long idle spells stay legal
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            gap_q <= 8'hFF;
        else if ($rose(trig_out))
            gap_q <= 8'h01;
        else if (gap_q != 8'hFF)
            gap_q <= gap_q + 8'h01;
    end
    sequence s_run;
        (run_in && supplies_ok_in && res_ready_in)[*8];
    endsequence
    sequence s_busy;
        busy_in[*3];
    endsequence
    pulse_width_a: assert property ($rose(trig_out) |=> !trig_out) else $error("trigger high too long");
    low_min_a: assert property ($fell(trig_out) |=> !trig_out) else $error("trigger low too short");
    trig_rate_a: assert property ($rose(trig_out) |-> gap_q >= PERIOD_CYC) else $error("trigger too soon");
    run_train_a: assert property (s_run |-> ##[0:40] trig_out) else $error("train stalled");
    supply_gate_a: assert property (!supplies_ok_in |=> !$rose(trig_out)) else $error("trigger unpowered");
    busy_gate_a: assert property (s_busy |=> !$rose(trig_out)) else $error("trigger while busy");
endmodule
bind atr_ctrl atr_ctrl_chk #(.PERIOD_CYC(PERIOD_CYC)) u_chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .supplies_ok_in(supplies_ok_in), .run_in(run_in), .busy_in(busy_in), .res_ready_in(res_ready_in),
    .trig_out(trig_out));

//--- verif/atr_conv_model.sv
// behavioural converter on the far side of the trigger controller
`timescale 1ns/1ps
module atr_conv_model
#(
    parameter int CONV_NS = 400
)
(
    input wire logic trig_in,
    input wire logic [13:0] code_in,
    output logic busy_out,
    output logic [13:0] data_out,
    output logic bad_out
);
    realtime start_t = 0;
    logic spoil = 1'b0;
    initial
    begin
        busy_out = 1'b0;
        data_out = 14'h0000;
        bad_out = 1'b0;
    end
    // only a rising edge starts; a retrigger while busy spoils the run
    always @(posedge trig_in)
    begin
        spoil = busy_out;
        busy_out = 1'b1;
        start_t = $realtime;
    end
    // pins churn mid-conversion so an early capture cannot match by luck
    always #10
    begin
        if (busy_out && $realtime - start_t >= CONV_NS)
        begin
            busy_out = 1'b0;
            bad_out = spoil;
            data_out = code_in;
        end
        else if (busy_out)
            data_out = ~data_out;
    end
endmodule

//--- verif/testbench.sv
// self-checking bench for the converter trigger controller
`timescale 1ns/1ps
`include "atr_params.svh"
module testbench;
    import atr_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic supplies_ok_in = 1'b0;
    logic run_in = 1'b0;
    logic single_in = 1'b0;
    logic res_ready_in = 1'b0;
    logic [13:0] code = 14'h2000;
    logic busy_in, trig_out, res_valid_out, res_invalid_out, overrun_out, converting_out, bad;
    logic [13:0] adc_data_in, res_data_out;
    int failures = 0;
    int comparisons = 0;
    int trigs = 0;
    logic [13:0] codes [8] = '{14'h3FFF, 14'h3800, 14'h3000, 14'h2000, 14'h1000, 14'h0800, 14'h0001, 14'h0000};
    // clock and a count of issued triggers
    always #25 ref_clk_in = ~ref_clk_in;
    always @(posedge trig_out) trigs++;
    // clock enable is tied on: freezing is not exercised here
    atr_ctrl dut (.ref_clk_in, .rst_b_in, .ce_in(1'b1), .supplies_ok_in, .run_in, .single_in, .busy_in,
        .adc_data_in, .trig_out, .res_valid_out, .res_ready_in, .res_data_out, .res_invalid_out, .overrun_out,
        .converting_out);
    atr_conv_model conv (.trig_in(trig_out), .code_in(code), .busy_out(busy_in), .data_out(adc_data_in),
        .bad_out(bad));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask
    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // bounded wait for a result word at the buffer output
    task automatic wait_valid();
        int n;
        n = 0;
        while (res_valid_out !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        if (res_valid_out !== 1'b1)
        begin
            failures++;
            test_done();
        end
    endtask
    task automatic pulse_single();
        single_in = 1'b1;
        tick(1);
        single_in = 1'b0;
    endtask
    // a request while supplies are off must wait, then run once they come up
    task automatic t_supply();
        res_ready_in = 1'b1;
        pulse_single();
        tick(40);
        chk("trigs unpowered", 14'h0000, 14'(trigs));
        supplies_ok_in = 1'b1;
        wait_valid();
        chk("first", 14'h2000, res_data_out);
        tick(1);
        $display("supply gate done");
    endtask
    // every listed code point passes through unchanged and unflagged
    task automatic t_codes();
        foreach (codes[i])
        begin
            code = codes[i];
            pulse_single();
            // busy has passed both sync flops by now and the result is still far off
            tick(5);
            chk("converting", 14'h0001, {13'h0, converting_out});
            wait_valid();
            chk("code", codes[i], res_data_out);
            chk("invalid", 14'h0000, {13'h0, res_invalid_out});
            chk("spoiled", 14'h0000, {13'h0, bad});
            tick(1);
            chk("converting idle", 14'h0000, {13'h0, converting_out});
        end
        $display("code map done");
    endtask
    // consumer stalls: two words fill the buffer, the third waits, none lost
    task automatic t_stall();
        int t0;
        t0 = trigs;
        res_ready_in = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            code = 14'h0ABC + 14'(i);
            pulse_single();
            tick(40);
        end
        chk("trigs stalled", 14'(t0 + 2), 14'(trigs));
        chk("overrun", 14'h0000, {13'h0, overrun_out});
        res_ready_in = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            wait_valid();
            chk("drained", 14'h0ABC + 14'(i), res_data_out);
            tick(1);
        end
        $display("stall done");
    endtask
    // continuous train: spacing between rises stays at or above the 3MHz cap
    task automatic t_run();
        int n;
        n = 0;
        run_in = 1'b1;
        while (trig_out !== 1'b1 && n < 60)
        begin
            tick(1);
            n++;
        end
        if (trig_out !== 1'b1)
        begin
            failures++;
            test_done();
        end
        // whole cycles from one rise to the next
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (trig_out !== 1'b1 && n < 60);
        run_in = 1'b0;
        if (trig_out !== 1'b1)
        begin
            failures++;
            test_done();
        end
        chk("spacing", 14'h0001, {13'h0, n >= `ATR_PERIOD_CYC && n < 40});
        tick(60);
        $display("run train done");
    endtask
    initial
    begin
        tick(6);
        rst_b_in = 1'b1;
        tick(2);
        t_supply();
        t_codes();
        t_stall();
        t_run();
        test_done();
    end
endmodule
